// ### rtcc_calendar.v
// Behaviour
// - Calendar counting and layout apply while counter mode select is 0.
// - All counters are packed BCD, tens in upper nibble.
// - Each digit stays 0 to 9 and carries past 9.
// - Reset gives 00:00:00.00, 2000-01-01, weekday 6, halt flag 1, monitor 0.
// - Unimplemented bits of time registers read as zero.
// - Hundredths count only when enabled, otherwise read zero.
// - Hour format follows the 12/24 select; bit 5 is AM/PM in 12-hour.
// - Years divisible by four give February a 29th day.
// - Weekday is bits 2:0 counting 0 to 6, default 6.
// - Weekday is a plain modulo-7 count with no fixed meaning.
// - Month is BCD in bits 4:0, 01 to 12.
// - Halt flag, seconds bit 7, sets while the crystal is stopped.
// - Start-up until stable resonance counts as a stop.
// - Halt flag stays set until software writes it clear.
// - Clearing while the crystal is stopped has no effect.
// - Event monitor, minutes bit 7, reads 1 when any flag is set.
// - Event monitor ignores writes and clears only when all flags clear.
// - A read copies counters into a holding register while counting continues.
//
// Decided for this implementation: register access over AXI4-Lite.
`include "rtcc_defines.vh"

module rtcc_calendar #(
  parameter TICK_DIV = `RTCC_TICK_DIV,
  parameter STARTUP_CYC = `RTCC_STARTUP_CYC
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Crystal status and flag summary
  input wire crystal_running,
  input wire flags_pending
);
  reg [7:0] hund_reg;
  reg [7:0] sec_reg;
  reg [7:0] min_reg;
  reg [7:0] hour_reg;
  reg [7:0] day_reg;
  reg [2:0] wday_reg;
  reg [7:0] mon_reg;
  reg [7:0] year_reg;
  reg crystal_halt_flag_reg;
  reg event_monitor_flag_reg;
  reg counter_mode_select_reg;
  reg hour_mode_12_reg;
  reg hundredths_enable_reg;
  reg [24:0] div_reg;
  reg [24:0] start_reg;
  reg [5:0] awaddr_reg;
  reg aw_have_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_have_reg;
  wire osc_ok;
  wire tick;
  wire started;
  wire run;
  wire do_write;
  wire [3:0] widx;
  wire [7:0] wb;
  wire [3:0] ridx;
  reg [7:0] rbyte;
  reg [7:0] dmax;
  reg [7:0] hnext;
  reg [7:0] hinc;

  rtcc_sync rtcc_sync_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(crystal_running),
    .dout(osc_ok)
  );

  // BCD increment; callers wrap at their own limit.
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  assign started = (start_reg == STARTUP_CYC[24:0]);
  assign run = osc_ok && started;
  assign tick = run && (div_reg == TICK_DIV[24:0] - 25'h1);

  // The prescaler only runs on a good crystal, so a stop freezes time.
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 25'h0;
      start_reg <= 25'h0;
    end else begin
      if (!osc_ok) begin
        start_reg <= 25'h0;
      end else if (!started) begin
        start_reg <= start_reg + 25'h1;
      end
      if (!run || tick) begin
        div_reg <= 25'h0;
      end else begin
        div_reg <= div_reg + 25'h1;
      end
    end
  end

  // Days in month; leap test uses BCD year, divisible by four.
  always @* begin
    case (mon_reg)
      8'h02: dmax = ((year_reg[4] ? year_reg[1:0] == 2'b10 : year_reg[1:0] == 2'b00)
                     ? 8'h29 : 8'h28);
      8'h04, 8'h06, 8'h09, 8'h11: dmax = 8'h30;
      default: dmax = 8'h31;
    endcase
  end

  // The half-day bit is carried separately so the digit increment cannot disturb it.
  always @* begin
    hinc = bcd_inc({3'h0, hour_reg[4:0]});
    if (hour_mode_12_reg) begin
      if ({3'h0, hour_reg[4:0]} == `RTCC_BCD_H12) begin
        hnext = {hour_reg[7:5], 5'h01};
      end else if ({3'h0, hour_reg[4:0]} == `RTCC_BCD_H11) begin
        hnext = {2'b00, ~hour_reg[`RTCC_PM_BIT], 5'h12};
      end else begin
        hnext = {2'b00, hour_reg[`RTCC_PM_BIT], hinc[4:0]};
      end
    end else begin
      hnext = (hour_reg == `RTCC_BCD_MAX_H24) ? 8'h00 : bcd_inc(hour_reg);
    end
  end

  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign widx = awaddr_reg[5:2];
  assign wb = wdata_reg[7:0];
  assign ridx = s_axi_araddr[5:2];

  // Counter and control registers.
  always @(posedge aclk) begin
    if (!aresetn) begin
      hund_reg <= `RTCC_RST_ZERO;
      sec_reg <= `RTCC_RST_ZERO;
      min_reg <= `RTCC_RST_ZERO;
      hour_reg <= `RTCC_RST_ZERO;
      day_reg <= `RTCC_RST_ONE;
      wday_reg <= `RTCC_RST_WDAY;
      mon_reg <= `RTCC_RST_ONE;
      year_reg <= `RTCC_RST_ZERO;
      crystal_halt_flag_reg <= 1'b1;
      event_monitor_flag_reg <= 1'b0;
      counter_mode_select_reg <= 1'b0;
      hour_mode_12_reg <= 1'b0;
      hundredths_enable_reg <= 1'b1;
    end else begin
      event_monitor_flag_reg <= flags_pending;
      if (!run) begin
        crystal_halt_flag_reg <= 1'b1;
      end else if (do_write && wstrb_reg[0] && widx == `RTCC_IDX_SEC
                   && !wb[`RTCC_HALT_BIT]) begin
        crystal_halt_flag_reg <= 1'b0;
      end
      if (tick && !counter_mode_select_reg) begin
        if (!hundredths_enable_reg || hund_reg == `RTCC_BCD_MAX_HUND) begin
          hund_reg <= `RTCC_RST_ZERO;
          if (sec_reg == `RTCC_BCD_MAX_SEC) begin
            sec_reg <= `RTCC_RST_ZERO;
            if (min_reg == `RTCC_BCD_MAX_SEC) begin
              min_reg <= `RTCC_RST_ZERO;
              hour_reg <= hnext;
              if ((hour_mode_12_reg && hour_reg[`RTCC_PM_BIT]
                   && {3'h0, hour_reg[4:0]} == `RTCC_BCD_H11)
                  || (!hour_mode_12_reg && hour_reg == `RTCC_BCD_MAX_H24)) begin
                wday_reg <= (wday_reg == `RTCC_WDAY_MAX) ? 3'h0 : wday_reg + 3'h1;
                if (day_reg == dmax) begin
                  day_reg <= `RTCC_RST_ONE;
                  if (mon_reg == `RTCC_BCD_MAX_MON) begin
                    mon_reg <= `RTCC_RST_ONE;
                    year_reg <= (year_reg == `RTCC_BCD_MAX_YEAR) ? 8'h00
                                : bcd_inc(year_reg);
                  end else begin
                    mon_reg <= bcd_inc(mon_reg);
                  end
                end else begin
                  day_reg <= bcd_inc(day_reg);
                end
              end
            end else begin
              min_reg <= bcd_inc(min_reg);
            end
          end else begin
            sec_reg <= bcd_inc(sec_reg);
          end
        end else begin
          hund_reg <= bcd_inc(hund_reg);
        end
      end
      if (do_write && wstrb_reg[0]) begin
        case (widx)
          `RTCC_IDX_HUND: hund_reg <= wb;
          `RTCC_IDX_SEC: sec_reg <= {1'b0, wb[6:0]};
          `RTCC_IDX_MIN: min_reg <= {1'b0, wb[6:0]};
          `RTCC_IDX_HOUR: hour_reg <= wb & (hour_mode_12_reg ? 8'h3f : 8'h3f);
          `RTCC_IDX_DAY: day_reg <= wb & 8'h3f;
          `RTCC_IDX_WDAY: wday_reg <= wb[2:0];
          `RTCC_IDX_MON: mon_reg <= wb & 8'h1f;
          `RTCC_IDX_YEAR: year_reg <= wb;
          `RTCC_IDX_CTRL: begin
            counter_mode_select_reg <= wb[`RTCC_CTRL_MODE];
            hour_mode_12_reg <= wb[`RTCC_CTRL_H12];
            hundredths_enable_reg <= wb[`RTCC_CTRL_HUND];
          end
          // Unmapped writes must not cancel a tick that lands in the same cycle.
          default: begin
          end
        endcase
      end
    end
  end

  // Read view of the live counters.
  always @* begin
    case (ridx)
      `RTCC_IDX_HUND: rbyte = hundredths_enable_reg ? hund_reg : 8'h00;
      `RTCC_IDX_SEC: rbyte = {crystal_halt_flag_reg, sec_reg[6:0]};
      `RTCC_IDX_MIN: rbyte = {event_monitor_flag_reg, min_reg[6:0]};
      `RTCC_IDX_HOUR: rbyte = hour_mode_12_reg ? hour_reg & 8'h3f : hour_reg & 8'h3f;
      `RTCC_IDX_DAY: rbyte = day_reg & 8'h3f;
      `RTCC_IDX_WDAY: rbyte = {5'h00, wday_reg};
      `RTCC_IDX_MON: rbyte = mon_reg & 8'h1f;
      `RTCC_IDX_YEAR: rbyte = year_reg;
      `RTCC_IDX_CTRL: rbyte = {5'h00, hundredths_enable_reg, hour_mode_12_reg,
                               counter_mode_select_reg};
      default: rbyte = 8'h00;
    endcase
  end

  // AXI4-Lite slave: address and data may arrive in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RTCC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RTCC_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 6'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (widx > `RTCC_IDX_LAST) ? `RTCC_RESP_SLVERR : `RTCC_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        // The holding copy lets the counters run on during the read.
        s_axi_rdata <= {24'h0, rbyte};
        s_axi_rresp <= (ridx > `RTCC_IDX_LAST) ? `RTCC_RESP_SLVERR : `RTCC_RESP_OKAY;
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ### rtcc_calendar_monitor.sv
`include "rtcc_defines.vh"
module rtcc_calendar_monitor (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Read channels
  input logic [5:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Status inputs
  input logic crystal_running,
  input logic flags_pending
);
  timeunit 1ns;
  timeprecision 1ns;
  // Run lengths saturate at seven so checks wait out the input synchronisers.
  logic [3:0] ra_reg;
  logic [2:0] stop_reg;
  logic [2:0] fhi_reg;
  logic [2:0] flo_reg;
  function automatic logic [2:0] sat(input logic [2:0] c, input logic go);
    sat = !go ? 3'h0 : (c == 3'h7 ? c : c + 3'h1);
  endfunction
  always @(posedge aclk) begin
    stop_reg <= aresetn ? sat(stop_reg, !crystal_running) : 3'h0;
    fhi_reg <= aresetn ? sat(fhi_reg, flags_pending) : 3'h0;
    flo_reg <= aresetn ? sat(flo_reg, !flags_pending) : 3'h0;
    if (!aresetn)
      ra_reg <= 4'h0;
    else if (s_axi_arvalid && s_axi_arready)
      ra_reg <= s_axi_araddr[5:2];
  end
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_RD_HIGH: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_RD_UNIT: assert property (s_axi_rvalid && ra_reg < 4'h8 |-> s_axi_rdata[3:0] <= 4'h9)
    else $error("unit digit above nine");
  AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_HALT_SET: assert property ($rose(s_axi_rvalid) && ra_reg == 4'h1 && stop_reg == 3'h7 |-> s_axi_rdata[7])
    else $error("halt flag clear while stopped");
  AST_MON_SET: assert property ($rose(s_axi_rvalid) && ra_reg == 4'h2 && fhi_reg == 3'h7 |-> s_axi_rdata[7])
    else $error("monitor low with flags set");
  AST_MON_CLR: assert property ($rose(s_axi_rvalid) && ra_reg == 4'h2 && flo_reg == 3'h7 |-> !s_axi_rdata[7])
    else $error("monitor high with no flags");
  AST_WDAY: assert property (s_axi_rvalid && ra_reg == 4'h5 |-> s_axi_rdata[7:0] <= 8'h06)
    else $error("weekday out of range");
  AST_MONTH: assert property (s_axi_rvalid && ra_reg == 4'h6 |-> s_axi_rdata[7:5] == 3'h0)
    else $error("month high bits set");
  AST_HOUR: assert property (s_axi_rvalid && ra_reg == 4'h3 |-> s_axi_rdata[7:6] == 2'h0)
    else $error("hour high bits set");
endmodule

// ### rtcc_calendar_tb.sv
`include "rtcc_defines.vh"
module rtcc_calendar_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, crystal_running, flags_pending;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] rv;
  int num_errors = 0;
  int check_count = 0;
  rtcc_calendar #(.TICK_DIV(4), .STARTUP_CYC(8)) rtcc_calendar_inst (.*);
  rtcc_host_model rtcc_host_model_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    rtcc_host_model_inst.wr(a, d, rs);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string m);
    rtcc_host_model_inst.rd(a, rv, rs);
    chk(rv, e, m);
  endtask
  task automatic t_reset;
    logic [7:0] e[9] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h06, 8'h01, 8'h00, 8'h04};
    for (int i = 0; i < 9; i++) rdc(6'(i * 4), e[i], "reset value");
    wr(6'h04, 8'h00);
    rdc(6'h04, 8'h80, "clear while stopped");
    @(posedge aclk) crystal_running <= 1'b1;
    wr(6'h20, 8'h05);
    repeat (20) @(posedge aclk);
    rdc(6'h04, 8'h80, "flag after restart");
    wr(6'h04, 8'h00);
    rdc(6'h04, 8'h00, "flag cleared");
    @(posedge aclk) crystal_running <= 1'b0;
    repeat (10) @(posedge aclk);
    crystal_running <= 1'b1;
    rdc(6'h04, 8'h80, "flag after stop");
    repeat (20) @(posedge aclk);
    $display("test reset_and_halt done");
  endtask
  // Counting runs about eight ticks, so only the hundredths move after the carry.
  task automatic roll(input logic [7:0] c, h, d, m, y, eh, ed, ew, em, ey);
    logic [7:0] v[8];
    v = '{8'h99, 8'h59, 8'h59, h, d, 8'h06, m, y};
    wr(6'h20, c | 8'h01);
    for (int i = 0; i < 8; i++) wr(6'(i * 4), v[i]);
    wr(6'h20, c);
    repeat (30) @(posedge aclk);
    wr(6'h20, c | 8'h01);
    rdc(6'h04, 8'h00, "seconds");
    rdc(6'h08, 8'h00, "minutes");
    rdc(6'h0c, eh, "hours");
    rdc(6'h10, ed, "day");
    rdc(6'h14, ew, "weekday");
    rdc(6'h18, em, "month");
    rdc(6'h1c, ey, "year");
    $display("test rollover done");
  endtask
  task automatic t_misc;
    wr(6'h20, 8'h00);
    repeat (20) @(posedge aclk);
    wr(6'h20, 8'h01);
    rdc(6'h00, 8'h00, "hundredths off");
    wr(6'h04, 8'h30);
    chk({6'h0, rs}, {6'h0, `RTCC_RESP_OKAY}, "write resp");
    repeat (20) @(posedge aclk);
    rdc(6'h04, 8'h30, "frozen in counter mode");
    chk({6'h0, rs}, {6'h0, `RTCC_RESP_OKAY}, "read resp");
    wr(6'h08, 8'h85);
    rdc(6'h08, 8'h05, "monitor write");
    @(posedge aclk) flags_pending <= 1'b1;
    repeat (3) @(posedge aclk);
    rdc(6'h08, 8'h85, "monitor set");
    wr(6'h08, 8'h05);
    rdc(6'h08, 8'h85, "monitor kept");
    @(posedge aclk) flags_pending <= 1'b0;
    repeat (3) @(posedge aclk);
    rdc(6'h08, 8'h05, "monitor clear");
    wr(6'h24, 8'h12);
    chk({6'h0, rs}, {6'h0, `RTCC_RESP_SLVERR}, "unmapped write resp");
    rdc(6'h24, 8'h00, "unmapped data");
    chk({6'h0, rs}, {6'h0, `RTCC_RESP_SLVERR}, "unmapped resp");
    $display("test misc done");
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test;
  end
  initial begin
    aresetn = 1'b0;
    crystal_running = 1'b0;
    flags_pending = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    roll(8'h04, 8'h23, 8'h31, 8'h12, 8'h99, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00);
    roll(8'h04, 8'h23, 8'h28, 8'h02, 8'h04, 8'h00, 8'h29, 8'h00, 8'h02, 8'h04);
    roll(8'h04, 8'h23, 8'h28, 8'h02, 8'h01, 8'h00, 8'h01, 8'h00, 8'h03, 8'h01);
    roll(8'h04, 8'h23, 8'h30, 8'h04, 8'h05, 8'h00, 8'h01, 8'h00, 8'h05, 8'h05);
    roll(8'h06, 8'h31, 8'h09, 8'h01, 8'h10, 8'h12, 8'h10, 8'h00, 8'h01, 8'h10);
    roll(8'h06, 8'h11, 8'h09, 8'h01, 8'h10, 8'h32, 8'h09, 8'h06, 8'h01, 8'h10);
    t_misc;
    finish_test;
  end
endmodule
bind rtcc_calendar rtcc_calendar_monitor rtcc_calendar_monitor_inst (.*);

// ### rtcc_defines.vh
`ifndef RTCC_DEFINES_VH
`define RTCC_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define RTCC_IDX_HUND 4'h0
`define RTCC_IDX_SEC 4'h1
`define RTCC_IDX_MIN 4'h2
`define RTCC_IDX_HOUR 4'h3
`define RTCC_IDX_DAY 4'h4
`define RTCC_IDX_WDAY 4'h5
`define RTCC_IDX_MON 4'h6
`define RTCC_IDX_YEAR 4'h7
`define RTCC_IDX_CTRL 4'h8
`define RTCC_IDX_LAST 4'h8

// Control register fields.
`define RTCC_CTRL_MODE 0
`define RTCC_CTRL_H12 1
`define RTCC_CTRL_HUND 2

// Bit positions inside time registers.
`define RTCC_HALT_BIT 7
`define RTCC_EVENT_MONITOR_FLAG_BIT 7
`define RTCC_PM_BIT 5

// Reset values.
`define RTCC_RST_ZERO 8'h00
`define RTCC_RST_ONE 8'h01
`define RTCC_RST_WDAY 3'h6
`define RTCC_RST_CTRL 8'h04

// BCD limits.
`define RTCC_BCD_MAX_HUND 8'h99
`define RTCC_BCD_MAX_SEC 8'h59
`define RTCC_BCD_MAX_H24 8'h23
`define RTCC_BCD_H11 8'h11
`define RTCC_BCD_H12 8'h12
`define RTCC_BCD_MAX_MON 8'h12
`define RTCC_BCD_MAX_YEAR 8'h99
`define RTCC_BCD_FEB 8'h02
`define RTCC_WDAY_MAX 3'h6

// Timing.
`define RTCC_CLK_HZ 20000000
`define RTCC_TICK_HZ 100
`define RTCC_TICK_DIV (`RTCC_CLK_HZ / `RTCC_TICK_HZ)
`define RTCC_STARTUP_MS 200
`define RTCC_STARTUP_CYC (`RTCC_CLK_HZ / 1000 * `RTCC_STARTUP_MS)

// AXI responses.
`define RTCC_RESP_OKAY 2'b00
`define RTCC_RESP_SLVERR 2'b10

`endif

// ### rtcc_host_model.sv
module rtcc_host_model (
  // Clock
  input logic aclk,
  // Write address and data
  output logic [5:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input logic s_axi_wready,
  // Write response
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read
  output logic [5:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Released payloads are inverted so a stale value is never mistaken for a live one.
  task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~{24'h0, d};
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ### rtcc_sync.v
`include "rtcc_defines.vh"

module rtcc_sync (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Raw and filtered level
  input wire din,
  output reg dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // A change is only accepted once the second and third stages agree.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule
